//--- common/uart_pkg.sv
// constants, field layout and state types of the two-mode serial port
package uart_pkg;

  // ==========================================================
  // register map (byte addresses on the APB bus)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] BUF_OFFSET = 8'h04;

  // ==========================================================
  // serial_control field positions
  localparam int RXDONE_POS = 0;
  localparam int TXDONE_POS = 1;
  localparam int NINTH_POS = 2;
  localparam int RXEN_POS = 4;
  localparam int QUAL_POS = 5;
  localparam int MODE_LOW_POS = 6;
  localparam int MODE_HIGH_POS = 7;
  localparam int FAST_BAUD_POS = 8;
  localparam int CTRL_WIDTH = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // ==========================================================
  // mode select encodings
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC = 2'h1;

  // ==========================================================
  // shift mode timing, in oscillator periods
  localparam logic [3:0] M0_FAST_LEN = 4'h4;
  localparam logic [3:0] M0_FAST_LEAD = 4'h1;
  localparam logic [3:0] M0_FAST_LOW = 4'h2;
  localparam logic [3:0] M0_SLOW_LEN = 4'hc;
  localparam logic [3:0] M0_SLOW_LEAD = 4'h3;
  localparam logic [3:0] M0_SLOW_LOW = 4'h6;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;

  // ==========================================================
  // asynchronous mode counts
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] VOTE_STATE = 4'h9;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [3:0] RX_STOP_BIT = 4'h9;

  // ==========================================================
  // state types
  typedef enum logic [1:0] {SH_IDLE, SH_TX, SH_RX} shift_state_t;
  typedef enum logic {RX_HUNT, RX_FRAME} rx_state_t;

endpackage

//--- verilog/serial_port.sv
// serial port with synchronous shift mode and 10-bit asynchronous mode
// Operation
// - buffer write loads transmitter, read returns receiver
// - async transmitter and receiver run independently
// - shift mode: data on rxd, clock on txd
// - shift mode frames 8 bits, lsb first
// - shift rate osc/12 or osc/4 by qualifier
// - shift mode buffer write starts transmission
// - fast: data 1 before fall, low 2
// - slow: data 3 before fall, low 6
// - shift mode tx done after last bit
// - shift receive needs enable and done clear
// - rx done after last rise blocks reception
// - async frame: start, 8 data, stop
// - async rate overflow/16 or overflow/32
// - tx bits leave after divider rollovers
// - tx done at tenth rollover with stop
// - receiver idle unless enabled, falling edge starts
// - sample 16x, falling edge resets divider
// - bit value is majority of states 7-9
// - start bit not zero aborts reception
// - load buffer only if done clear, qualifier ok
// - receiver hunts again after stop middle
`timescale 1ns/10ps
module serial_port (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // baud source
  input wire logic timer_overflow_i,
  // serial pins
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o
);
  import uart_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    shift_state_t sh;
    logic [3:0] ph;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [7:0] rxbuf;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic half;
    logic tx_busy;
    logic [3:0] tx_div;
    logic [3:0] tx_bits;
    logic [9:0] tx_sh;
    logic tx_line;
    rx_state_t rs;
    logic [3:0] rx_div;
    logic [3:0] rx_bits;
    logic [1:0] votes;
    logic [7:0] rx_sh;
    logic rx_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================================
  // decode helpers
  function automatic logic [3:0] m0_len(input logic q);
    m0_len = q ? M0_FAST_LEN : M0_SLOW_LEN;
  endfunction

  function automatic logic [3:0] m0_fall(input logic q);
    m0_fall = q ? M0_FAST_LEAD : M0_SLOW_LEAD;
  endfunction

  function automatic logic [3:0] m0_rise(input logic q);
    m0_rise = q ? (M0_FAST_LEAD + M0_FAST_LOW) : (M0_SLOW_LEAD + M0_SLOW_LOW);
  endfunction

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  logic access;
  logic buf_wr;
  logic ctrl_wr;
  logic tick16;
  logic vote;
  logic [1:0] mode;
  logic qual;

  assign access = psel_i & penable_i & s.pready;
  assign buf_wr = access & pwrite_i & (paddr_i == BUF_OFFSET);
  assign ctrl_wr = access & pwrite_i & (paddr_i == CTRL_OFFSET);
  // double rate uses every overflow, otherwise every second one
  assign tick16 = timer_overflow_i & (s.ctrl[FAST_BAUD_POS] | s.half);
  assign vote = majority(s.votes[1], s.votes[0], rxd_i);
  assign mode = s.ctrl[MODE_HIGH_POS:MODE_LOW_POS];
  assign qual = s.ctrl[QUAL_POS];

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;

    // apb: one wait state, answer registered
    next_s.pready = psel_i & penable_i & ~s.pready;
    next_s.prdata = 32'h0000_0000;
    next_s.pslverr = 1'b0;
    if (psel_i & penable_i & ~s.pready) begin
      if (paddr_i == CTRL_OFFSET) begin
        next_s.prdata = {23'h0, s.ctrl};
      end else if (paddr_i == BUF_OFFSET) begin
        next_s.prdata = {24'h000000, s.rxbuf};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // control write: flags can only be cleared, ninth bit is read-only
    if (ctrl_wr) begin
      next_s.ctrl = pwdata_i[CTRL_WIDTH-1:0];
      next_s.ctrl[NINTH_POS] = s.ctrl[NINTH_POS];
      next_s.ctrl[RXDONE_POS] = s.ctrl[RXDONE_POS] & pwdata_i[RXDONE_POS];
      next_s.ctrl[TXDONE_POS] = s.ctrl[TXDONE_POS] & pwdata_i[TXDONE_POS];
      next_s.ctrl[3] = 1'b0;
    end

    // ========================================================
    // shift mode engine
    if (mode == MODE_SHIFT) begin
      if (s.sh == SH_IDLE) begin
        if (buf_wr) begin
          // a write while shifting is dropped to keep the frame intact
          next_s.sh = SH_TX;
          next_s.ph = 4'h0;
          next_s.bitn = 4'h0;
          next_s.shreg = pwdata_i[7:0];
          next_s.rxd_out = pwdata_i[0];
          next_s.rxd_oe = 1'b1;
        end else if (s.ctrl[RXEN_POS] & ~s.ctrl[RXDONE_POS]) begin
          next_s.sh = SH_RX;
          next_s.ph = 4'h0;
          next_s.bitn = 4'h0;
          next_s.rxd_oe = 1'b0;
        end
      end else begin
        if (s.ph == m0_len(qual) - 4'h1) begin
          next_s.ph = 4'h0;
          next_s.bitn = s.bitn + 4'h1;
          if (s.sh == SH_TX) begin
            if (s.bitn == M0_LAST_BIT) begin
              next_s.sh = SH_IDLE;
              next_s.rxd_oe = 1'b0;
              next_s.ctrl[TXDONE_POS] = 1'b1;
            end else begin
              next_s.shreg = {1'b0, s.shreg[7:1]};
              next_s.rxd_out = s.shreg[1];
            end
          end
        end else begin
          next_s.ph = s.ph + 4'h1;
        end
        // first high cycle after the rise: partner data is settled
        if (s.sh == SH_RX && s.ph == m0_rise(qual)) begin
          next_s.shreg = {rxd_i, s.shreg[7:1]};
          if (s.bitn == M0_LAST_BIT) begin
            next_s.sh = SH_IDLE;
            next_s.rxbuf = {rxd_i, s.shreg[7:1]};
            next_s.ctrl[RXDONE_POS] = 1'b1;
          end
        end
      end
    end else begin
      next_s.sh = SH_IDLE;
      next_s.rxd_oe = 1'b0;
    end

    // ========================================================
    // asynchronous transmitter, free-running divider
    if (timer_overflow_i) begin
      next_s.half = ~s.half;
    end
    if (mode == MODE_ASYNC) begin
      if (buf_wr & ~s.tx_busy) begin
        next_s.tx_busy = 1'b1;
        next_s.tx_sh = {1'b1, pwdata_i[7:0], 1'b0};
        next_s.tx_bits = 4'h0;
      end
      if (tick16) begin
        next_s.tx_div = s.tx_div + 4'h1;
        if (s.tx_div == DIV_LAST && s.tx_busy) begin
          next_s.tx_line = s.tx_sh[0];
          next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
          next_s.tx_bits = s.tx_bits + 4'h1;
          if (s.tx_bits == TX_LAST_BIT) begin
            next_s.tx_busy = 1'b0;
            next_s.ctrl[TXDONE_POS] = 1'b1;
          end
        end
      end

      // ======================================================
      // asynchronous receiver, its own divider so both run at once
      if (tick16) begin
        next_s.rx_prev = rxd_i;
        next_s.rx_div = s.rx_div + 4'h1;
        next_s.votes = {s.votes[0], rxd_i};
        if (s.rs == RX_HUNT) begin
          if (s.ctrl[RXEN_POS] & s.rx_prev & ~rxd_i) begin
            next_s.rs = RX_FRAME;
            next_s.rx_div = 4'h0;
            next_s.rx_bits = 4'h0;
          end
        end else if (s.rx_div == VOTE_STATE) begin
          next_s.rx_bits = s.rx_bits + 4'h1;
          if (s.rx_bits == 4'h0) begin
            if (vote) begin
              next_s.rs = RX_HUNT;
            end
          end else if (s.rx_bits == RX_STOP_BIT) begin
            next_s.rs = RX_HUNT;
            if (~s.ctrl[RXDONE_POS] & (~qual | vote)) begin
              next_s.rxbuf = s.rx_sh;
              next_s.ctrl[NINTH_POS] = vote;
              next_s.ctrl[RXDONE_POS] = 1'b1;
            end
          end else begin
            next_s.rx_sh = {vote, s.rx_sh[7:1]};
          end
        end
      end
    end else begin
      next_s.tx_busy = 1'b0;
      next_s.tx_line = 1'b1;
      next_s.rs = RX_HUNT;
    end

    // txd carries the shift clock in shift mode, the line otherwise
    if (mode == MODE_SHIFT) begin
      next_s.txd = (next_s.sh == SH_IDLE) | (next_s.ph < m0_fall(qual)) |
                   (next_s.ph >= m0_rise(qual));
    end else begin
      next_s.txd = next_s.tx_line;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{sh: SH_IDLE, ctrl: CTRL_RESET, txd: 1'b1, rxd_out: 1'b1, tx_line: 1'b1,
             tx_sh: 10'h3ff, rs: RX_HUNT, rx_prev: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign rxd_o = s.rxd_out;
  assign rxd_oe_o = s.rxd_oe;
  assign txd_o = s.txd;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence fast_low_tail;
    !txd_o ##1 txd_o;
  endsequence

  sequence slow_low_tail;
    (!txd_o) [*5] ##1 txd_o;
  endsequence

  AST_FAST_LOW: assert property (
    (s.sh != SH_IDLE && qual && $fell(txd_o)) |-> ##1 fast_low_tail)
    else $error("fast shift clock low time wrong");

  AST_SLOW_LOW: assert property (
    (s.sh != SH_IDLE && !qual && $fell(txd_o)) |-> ##1 slow_low_tail)
    else $error("slow shift clock low time wrong");

  AST_FAST_LEAD: assert property (
    (s.sh == SH_TX && s.ph == 4'h0 && qual) |=> $fell(txd_o))
    else $error("fast data lead wrong");

  AST_SLOW_LEAD: assert property (
    (s.sh == SH_TX && s.ph == 4'h0 && !qual) |-> !$fell(txd_o) ##3 $fell(txd_o))
    else $error("slow data lead wrong");

  AST_BUF_START: assert property (
    (buf_wr && mode == MODE_SHIFT && s.sh == SH_IDLE) |=>
      (s.sh == SH_TX && rxd_oe_o && rxd_o == $past(pwdata_i[0])))
    else $error("buffer write did not start shifting");

  AST_M0_RX_GATE: assert property (
    $rose(s.sh == SH_RX) |-> ($past(s.ctrl[RXEN_POS]) && !$past(s.ctrl[RXDONE_POS])))
    else $error("shift reception started while blocked");

  AST_FLAG_HOLD: assert property (
    (s.ctrl[RXDONE_POS] && !ctrl_wr) |=> s.ctrl[RXDONE_POS])
    else $error("receive done flag dropped by hardware");

  AST_START_ABORT: assert property (
    (s.rs == RX_FRAME && tick16 && s.rx_div == VOTE_STATE && s.rx_bits == 4'h0 && vote)
      |=> s.rs == RX_HUNT)
    else $error("bad start bit not aborted");

  AST_EDGE_ALIGN: assert property (
    (mode == MODE_ASYNC && s.ctrl[RXEN_POS] && s.rs == RX_HUNT && tick16 &&
     s.rx_prev && !rxd_i) |=> (s.rx_div == 4'h0 && s.rs == RX_FRAME))
    else $error("falling edge did not align divider");

  AST_TX_START_BIT: assert property (
    (mode == MODE_ASYNC && s.tx_busy && s.tx_bits == 4'h0 && tick16 && s.tx_div == DIV_LAST)
      |=> !txd_o)
    else $error("start bit not low");

  AST_NO_OVERRUN: assert property (
    (s.rs == RX_FRAME && tick16 && s.rx_div == VOTE_STATE && s.rx_bits == RX_STOP_BIT &&
     s.ctrl[RXDONE_POS]) |=> $stable(s.rxbuf))
    else $error("receive buffer overwritten while full");

endmodule

//--- test/serial_partner.sv
// model of the external shift register and asynchronous terminal on the serial pins
`timescale 1ns/10ps
module serial_partner (
  // clocks
  input wire logic mclk_i,
  input wire logic shift_clk_i,
  // rxd pin
  input wire logic line_i,
  input wire logic oe_i,
  output logic drive_o
);
  logic async_mode = 1'b0;
  int bit_cycles = 32;
  logic [7:0] shift_in = 8'h00;
  logic [7:0] shift_out = 8'hff;
  logic [7:0] async_in = 8'h00;

  initial drive_o = 1'b1;

  // ==========================================================
  // shift mode
  always @(posedge shift_clk_i) begin
    if (!async_mode && oe_i) begin
      shift_in <= {line_i, shift_in[7:1]};
    end
  end

  // bits move on the falling clock so they are settled at the rise
  always @(negedge shift_clk_i) begin
    if (!async_mode && !oe_i) begin
      drive_o <= shift_out[0];
      shift_out <= {1'b1, shift_out[7:1]};
    end
  end

  // after the last zero has been sampled the line floats back to its pull-up
  always @(posedge shift_clk_i) begin
    if (!async_mode && !oe_i && shift_out == 8'hff) begin
      repeat (2) @(posedge mclk_i);
      drive_o <= 1'b1;
    end
  end

  // ==========================================================
  // asynchronous mode, sampled in mid bit
  always begin
    @(negedge shift_clk_i);
    if (async_mode) begin
      repeat (bit_cycles / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cycles) @(posedge mclk_i);
        async_in = {shift_clk_i, async_in[7:1]};
      end
    end
  end

  task automatic send_frame(input logic [7:0] data, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_o <= frame[i];
      repeat (bit_cycles) @(posedge mclk_i);
    end
    drive_o <= 1'b1;
  endtask

  // pulled-up line dips low for less than half a bit
  task automatic glitch(input int len);
    drive_o <= 1'b0;
    repeat (len) @(posedge mclk_i);
    drive_o <= 1'b1;
  endtask
endmodule

//--- test/tb_top.sv
// self-checking bench of the two-mode serial port
`timescale 1ns/10ps
module tb_top;
  import uart_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_overflow = 1'b0;
  logic rxd_o;
  logic rxd_oe;
  logic txd;
  logic partner_drive;
  logic rxd_line;
  logic [31:0] rdata;
  logic err;
  int num_errors = 0;
  int total_checks = 0;
  int txd_falls = 0;
  realtime t0, t1, t2, t3;

  // ==========================================================
  // clock, baud source and pin wiring
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) timer_overflow <= ~timer_overflow;
  always @(negedge txd) txd_falls++;
  assign rxd_line = rxd_oe ? rxd_o : partner_drive;

  serial_port i_serial_port (.mclk_i(mclk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_overflow_i(timer_overflow),
    .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd));
  serial_partner i_serial_partner (.mclk_i(mclk), .shift_clk_i(txd), .line_i(rxd_line),
    .oe_i(rxd_oe), .drive_o(partner_drive));

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
    total_checks++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    // one idle edge keeps a release and the next setup out of the same time step
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    check("bus answer", 32'h1, {31'h0, pready});
    check("wait states", 32'h1, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data, rdata, err);
  endtask

  task automatic expect_read(input string what, input logic [7:0] addr, input logic [31:0] mask,
                             input logic [31:0] expected);
    apb(1'b0, addr, 32'h0, rdata, err);
    check(what, expected, rdata & mask);
  endtask

  task automatic wait_flag(input int pos);
    int n;
    n = 0;
    rdata = 32'h0;
    while (rdata[pos] !== 1'b1 && n < 300) begin
      apb(1'b0, CTRL_OFFSET, 32'h0, rdata, err);
      n++;
    end
    check("done flag", 32'h1, {31'h0, rdata[pos]});
  endtask

  function automatic logic [31:0] ctrl(input logic [1:0] mode, input logic qual,
                                       input logic rxen, input logic fast, input logic keep);
    return {23'h0, fast, mode, qual, rxen, 3'h0, keep};
  endfunction

  // ==========================================================
  // scenarios
  task automatic s_reset;
    check("txd idle", 32'h1, {31'h0, txd});
    check("rxd drive", 32'h0, {31'h0, rxd_oe});
    expect_read("control reset", CTRL_OFFSET, 32'h1ff, {23'h0, CTRL_RESET});
    apb(1'b0, 8'h08, 32'h0, rdata, err);
    check("unmapped error", 32'h1, {31'h0, err});
  endtask

  task automatic s_shift_tx(input logic qual, input logic [7:0] data);
    i_serial_partner.async_mode = 1'b0;
    reg_write(CTRL_OFFSET, ctrl(MODE_SHIFT, qual, 1'b0, 1'b0, 1'b0));
    reg_write(BUF_OFFSET, {24'h0, data});
    @(posedge rxd_oe);
    t0 = $realtime;
    @(negedge txd);
    t1 = $realtime;
    @(posedge txd);
    t2 = $realtime;
    @(negedge txd);
    t3 = $realtime;
    check("lead", qual ? M0_FAST_LEAD : M0_SLOW_LEAD, int'((t1 - t0) / 25.0));
    check("low", qual ? M0_FAST_LOW : M0_SLOW_LOW, int'((t2 - t1) / 25.0));
    check("period", qual ? M0_FAST_LEN : M0_SLOW_LEN, int'((t3 - t1) / 25.0));
    wait_flag(TXDONE_POS);
    check("shift out", data, i_serial_partner.shift_in);
  endtask

  task automatic s_shift_rx(input logic qual, input logic [7:0] data);
    int falls;
    i_serial_partner.shift_out = data;
    reg_write(CTRL_OFFSET, ctrl(MODE_SHIFT, qual, 1'b1, 1'b0, 1'b0));
    wait_flag(RXDONE_POS);
    expect_read("shift in", BUF_OFFSET, 32'hff, {24'h0, data});
    falls = txd_falls;
    repeat (100) @(posedge mclk);
    check("blocked", falls, txd_falls);
    expect_read("flag held", CTRL_OFFSET, 32'h1, 32'h1);
    reg_write(CTRL_OFFSET, ctrl(MODE_SHIFT, qual, 1'b0, 1'b0, 1'b0));
  endtask

  task automatic s_async(input logic fast, input logic qual, input logic rxen, input logic keep,
                         input logic [7:0] tx, input logic [7:0] rx, input logic stop,
                         input logic load);
    i_serial_partner.async_mode = 1'b1;
    i_serial_partner.bit_cycles = fast ? 32 : 64;
    reg_write(CTRL_OFFSET, ctrl(MODE_ASYNC, qual, rxen, fast, keep));
    reg_write(BUF_OFFSET, {24'h0, tx});
    i_serial_partner.send_frame(rx, stop);
    repeat (4 * i_serial_partner.bit_cycles) @(posedge mclk);
    wait_flag(TXDONE_POS);
    check("async out", tx, i_serial_partner.async_in);
    apb(1'b0, CTRL_OFFSET, 32'h0, rdata, err);
    check("receive flag", load | keep, rdata[RXDONE_POS]);
    if (load) begin
      check("ninth bit", stop, rdata[NINTH_POS]);
      expect_read("async in", BUF_OFFSET, 32'hff, {24'h0, rx});
    end
  endtask

  task automatic s_false_start;
    reg_write(CTRL_OFFSET, ctrl(MODE_ASYNC, 1'b0, 1'b1, 1'b1, 1'b0));
    i_serial_partner.glitch(6);
    // long enough for a receiver that failed to abort to finish a whole frame
    repeat (352) @(posedge mclk);
    expect_read("false start", CTRL_OFFSET, 32'h1, 32'h0);
  endtask

  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    s_reset;
    s_shift_tx(1'b1, 8'ha5);
    s_shift_tx(1'b0, 8'h3c);
    s_shift_rx(1'b1, 8'h96);
    s_shift_rx(1'b0, 8'h4b);
    s_async(1'b1, 1'b0, 1'b1, 1'b0, 8'h5a, 8'hc3, 1'b1, 1'b1);
    s_async(1'b1, 1'b0, 1'b1, 1'b0, 8'h66, 8'h99, 1'b0, 1'b1);
    s_async(1'b1, 1'b1, 1'b1, 1'b0, 8'h81, 8'h7e, 1'b0, 1'b0);
    s_async(1'b1, 1'b0, 1'b0, 1'b0, 8'h18, 8'h24, 1'b1, 1'b0);
    s_false_start;
    s_async(1'b1, 1'b0, 1'b1, 1'b0, 8'he7, 8'h0f, 1'b1, 1'b1);
    s_async(1'b0, 1'b1, 1'b1, 1'b1, 8'h42, 8'hf0, 1'b1, 1'b0);
    expect_read("kept buffer", BUF_OFFSET, 32'hff, 32'h0f);
    print_verdict;
  end
endmodule
